// *** sol_output_latch.sv ***
`timescale 1ns/1ps
// Operation
// - Register 0 read returns module and terminal code
// - Absent terminal forces low three bits high
// - Register 1 always reads hardwired minus 240
// - Register 2 reads channels 8 to 15
// - Register 3 reads channels 0 to 7
// - Readback comes from latch, not switches
// - Any register 0 write opens all channels
// - Register 0 write equals backplane reset
// - Register 2 write sets channels 8 to 15
// - Register 3 write sets channels 0 to 7
// - One closes a switch, zero opens it
module sol_output_latch
  import sol_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Backplane
  input  wire logic         i_bp_rst,
  input  wire sol_req_type  i_req,
  output logic      [7:0]   o_rdata,
  output logic              o_rvalid,
  // Terminal module pins
  input  wire sol_term_type i_term,
  // Channel switch drives
  output logic      [15:0]  o_chan_close
);

  sol_term_type term_s;
  logic [7:0]   upper_r;
  logic [7:0]   lower_r;
  logic [7:0]   rdata_nxt;
  logic         card_reset;

  sol_pin_sync #(
    .W       (SOL_SYNC_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_term),
    .o_level (term_s)
  );

  function automatic logic [7:0] ident(input sol_term_type t);
    logic [2:0] low;
    low = t.term_present ? t.term_id : SOL_NO_TERM_ID;
    return {SOL_COMP_ID, low};
  endfunction : ident

  assign card_reset = i_rst || i_bp_rst ||
                      (i_req.wr && i_req.addr == SOL_REG_ID);

  // Command latches
  always_ff @(posedge i_clk) begin
    if (card_reset) begin
      upper_r <= SOL_CHAN_RESET;
      lower_r <= SOL_CHAN_RESET;
    end else if (i_req.wr) begin
      if (i_req.addr == SOL_REG_UPPER) begin
        upper_r <= i_req.wdata;
      end else if (i_req.addr == SOL_REG_LOWER) begin
        lower_r <= i_req.wdata;
      end
      // Register 1 write is ignored
    end
  end

  assign o_chan_close = {upper_r, lower_r};

  // Read decode
  always_comb begin
    if (i_req.addr == SOL_REG_ID) begin
      rdata_nxt = ident(term_s);
    end else if (i_req.addr == SOL_REG_CONST) begin
      rdata_nxt = SOL_CONST_VAL;
    end else if (i_req.addr == SOL_REG_UPPER) begin
      rdata_nxt = upper_r;
    end else begin
      rdata_nxt = lower_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= SOL_RDATA_RESET;
    end else if (i_req.rd) begin
      o_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
    end
  end

  // Checks
  property p_id_read;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == SOL_REG_ID)
        |=> (o_rdata[7:SOL_ID_LSB] == SOL_COMP_ID && o_rvalid);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("id read wrong");

  property p_no_term;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == SOL_REG_ID && !term_s.term_present)
        |=> o_rdata[SOL_ID_LSB-1:0] == SOL_NO_TERM_ID;
  endproperty
  a_no_term: assert property (p_no_term)
    else $error("absent terminal not flagged");

  property p_const;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == SOL_REG_CONST)
        |=> $signed({8'hff, o_rdata}) == -240;
  endproperty
  a_const: assert property (p_const)
    else $error("constant register wrong");

  property p_upper_rb;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == SOL_REG_UPPER)
        |=> o_rdata == $past(o_chan_close[15:SOL_UPPER_LSB]);
  endproperty
  a_upper_rb: assert property (p_upper_rb)
    else $error("upper readback wrong");

  property p_lower_rb;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == SOL_REG_LOWER)
        |=> o_rdata == $past(o_chan_close[SOL_UPPER_LSB-1:0]);
  endproperty
  a_lower_rb: assert property (p_lower_rb)
    else $error("lower readback wrong");

  property p_reset_write;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.wr && i_req.addr == SOL_REG_ID) |=> o_chan_close == 16'h0000;
  endproperty
  a_reset_write: assert property (p_reset_write)
    else $error("register 0 write left a channel closed");

  property p_bp_reset;
    @(posedge i_clk) disable iff (i_rst)
      i_bp_rst |=> o_chan_close == 16'h0000;
  endproperty
  a_bp_reset: assert property (p_bp_reset)
    else $error("backplane reset left a channel closed");

  property p_upper_wr;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.wr && i_req.addr == SOL_REG_UPPER && !i_bp_rst)
        |=> o_chan_close[15:SOL_UPPER_LSB] == $past(i_req.wdata)
            && $stable(o_chan_close[SOL_UPPER_LSB-1:0]);
  endproperty
  a_upper_wr: assert property (p_upper_wr)
    else $error("upper write not applied");

  property p_lower_wr;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.wr && i_req.addr == SOL_REG_LOWER && !i_bp_rst)
        |=> o_chan_close[SOL_UPPER_LSB-1:0] == $past(i_req.wdata)
            && $stable(o_chan_close[15:SOL_UPPER_LSB]);
  endproperty
  a_lower_wr: assert property (p_lower_wr)
    else $error("lower write not applied");

  property p_after_rst;
    @(posedge i_clk) $fell(i_rst) |-> o_chan_close == 16'h0000;
  endproperty
  a_after_rst: assert property (p_after_rst)
    else $error("latches not clear after reset");

  property p_const_wr;
    @(posedge i_clk) disable iff (i_rst)
      (i_req.wr && i_req.addr == SOL_REG_CONST && !i_bp_rst) |=> $stable(o_chan_close);
  endproperty
  a_const_wr: assert property (p_const_wr)
    else $error("register 1 write changed channels");

  c_upper_wr: cover property (@(posedge i_clk) disable iff (i_rst)
    i_req.wr && i_req.addr == SOL_REG_UPPER && i_req.wdata != 8'h00);
  c_reset_wr: cover property (@(posedge i_clk) disable iff (i_rst)
    o_chan_close != 16'h0000 ##1 (i_req.wr && i_req.addr == SOL_REG_ID));
  c_id_noterm: cover property (@(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.addr == SOL_REG_ID && !term_s.term_present);

endmodule : sol_output_latch

// *** sol_pkg.sv ***
package sol_pkg;

  localparam logic [1:0] SOL_REG_ID    = 2'h0;
  localparam logic [1:0] SOL_REG_CONST = 2'h1;
  localparam logic [1:0] SOL_REG_UPPER = 2'h2;
  localparam logic [1:0] SOL_REG_LOWER = 2'h3;

  localparam logic [7:0] SOL_CONST_VAL   = 8'h10;
  localparam logic [4:0] SOL_COMP_ID     = 5'h0b; // Arbitrary value
  localparam logic [2:0] SOL_NO_TERM_ID  = 3'h7;
  localparam logic [7:0] SOL_CHAN_RESET  = 8'h00;
  localparam logic [7:0] SOL_RDATA_RESET = 8'h00;
  localparam int         SOL_ID_LSB      = 3;
  localparam int         SOL_UPPER_LSB   = 8;
  localparam int         SOL_SYNC_W      = 4;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } sol_req_type;

  typedef struct packed {
    logic       term_present;
    logic [2:0] term_id;
  } sol_term_type;

endpackage : sol_pkg

// *** sol_pin_sync.sv ***
`timescale 1ns/1ps
module sol_pin_sync
  import sol_pkg::*;
#(
  parameter int W = SOL_SYNC_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Pins
  input  wire logic [W-1:0] i_pin,
  // Filtered level
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Bits change once stages two and three agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_level[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : sol_pin_sync

// *** sol_ctrl_model.sv ***
`timescale 1ns/1ps
module sol_ctrl_model
  import sol_pkg::*;
(
  // Clock
  input  wire logic       i_clk,
  // Backplane
  output sol_req_type     o_req,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial o_req = '0;
  // Signed view of a raw byte, upper data lines float high
  function automatic int to_dec(input logic [7:0] b);
    return int'($signed({8'hff, b}));
  endfunction : to_dec
  // One write strobe, qualifiers inverted after release
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge i_clk);
    o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // One read strobe, bounded wait for valid
  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(negedge i_clk);
    o_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    for (int n = 0; n < 4 && !ok; n++) begin
      if (n > 0) begin
        @(negedge i_clk);
      end
      if (i_rvalid === 1'b1) begin
        d  = i_rdata;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : sol_ctrl_model

// *** tb_sol_output_latch.sv ***
`timescale 1ns/1ps
module tb_sol_output_latch
  import sol_pkg::*;
;
  logic         clk;
  logic         rst;
  logic         bp_rst;
  sol_req_type  req;
  logic [7:0]   rdata;
  logic         rvalid;
  sol_term_type term;
  logic [15:0]  chan_close;
  int           miscompares;
  int           total_checks;
  logic [7:0]   last_rd;

  sol_output_latch u_dut (.i_clk(clk), .i_rst(rst), .i_bp_rst(bp_rst), .i_req(req),
    .o_rdata(rdata), .o_rvalid(rvalid), .i_term(term), .o_chan_close(chan_close));
  sol_ctrl_model u_ctrl (.i_clk(clk), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_ctrl.rd(a, d, ok);
    last_rd = d;
    if (ok !== 1'b1) begin
      miscompares++;
      results();
    end else begin
      check({8'h00, d}, {8'h00, exp});
    end
  endtask : rdchk

  // Latches clear after reset
  task automatic t_reset();
    check(chan_close, 16'h0000);
    rdchk(SOL_REG_UPPER, 8'h00);
    rdchk(SOL_REG_LOWER, 8'h00);
  endtask : t_reset

  // Identification with and without terminal, constant
  task automatic t_ident();
    term <= '{term_present: 1'b0, term_id: 3'h2};
    repeat (8) @(negedge clk);
    rdchk(SOL_REG_ID, {SOL_COMP_ID, 3'h7});
    term <= '{term_present: 1'b1, term_id: 3'h2};
    repeat (8) @(negedge clk);
    rdchk(SOL_REG_ID, {SOL_COMP_ID, 3'h2});
    rdchk(SOL_REG_CONST, 8'(-240));
    check(16'(u_ctrl.to_dec(last_rd)), 16'(-240));
  endtask : t_ident

  // Walking bits through both command bytes
  task automatic t_chan();
    logic [7:0] u;
    logic [7:0] l;
    for (int i = 0; i < 8; i++) begin
      u = 8'h01 << i;
      l = 8'h80 >> i;
      u_ctrl.wr(SOL_REG_UPPER, u);
      u_ctrl.wr(SOL_REG_LOWER, l);
      @(negedge clk);
      check(chan_close, {u, l});
      rdchk(SOL_REG_UPPER, u);
      rdchk(SOL_REG_LOWER, l);
    end
  endtask : t_chan

  // Register 1 write is ignored
  task automatic t_ignore();
    u_ctrl.wr(SOL_REG_CONST, 8'hff);
    @(negedge clk);
    check(chan_close, 16'h8001);
    rdchk(SOL_REG_ID, {SOL_COMP_ID, 3'h2});
  endtask : t_ignore

  // Reset write and backplane reset
  task automatic t_clear();
    u_ctrl.wr(SOL_REG_ID, 8'h5a);
    @(negedge clk);
    check(chan_close, 16'h0000);
    rdchk(SOL_REG_LOWER, 8'h00);
    u_ctrl.wr(SOL_REG_LOWER, 8'hff);
    @(negedge clk);
    check(chan_close, 16'h00ff);
    bp_rst <= 1'b1;
    u_ctrl.wr(SOL_REG_UPPER, 8'hff);
    bp_rst <= 1'b0;
    repeat (2) @(negedge clk);
    check(chan_close, 16'h0000);
    rdchk(SOL_REG_UPPER, 8'h00);
  endtask : t_clear

  initial begin
    miscompares  = 0;
    total_checks = 0;
    rst          = 1'b1;
    bp_rst       = 1'b0;
    term         = '0;
    repeat (8) @(negedge clk);
    rst <= 1'b0;
    t_reset();
    t_ident();
    t_chan();
    t_ignore();
    t_clear();
    results();
  end
endmodule : tb_sol_output_latch
